//--- link_irq_map.svh
`ifndef LINK_IRQ_MAP_SVH
`define LINK_IRQ_MAP_SVH

`define IEV_W            23
`define ISO_CTX_N        32
`define ADDR_W           8

`define IEV_SET_OFF      8'h80
`define IEV_CLR_OFF      8'h84
`define IEV_CTRL_OFF     8'hFC

`define IEV_LOST         22
`define IEV_SEC64        21
`define IEV_SYNC         20
`define IEV_PHY          19
`define IEV_REGFAIL      18
`define IEV_BUSRST       17
`define IEV_SELFID       16
`define IEV_SELFID2      15
`define IEV_LOCKERR      9
`define IEV_PWERR        8
`define IEV_ISO_RX       7
`define IEV_ISO_TX       6
`define IEV_RSP_PKT      5
`define IEV_REQ_PKT      4
`define IEV_RX_RSP       3
`define IEV_RX_REQ       2
`define IEV_TX_RSP       1
`define IEV_TX_REQ       0

`define IEV_LATCHED      23'h7F833F
`define IEV_RESET        23'h000000

`define CTRL_PRED_GAP    0
`define CTRL_PRED_ARB    1
`define CTRL_RESET       2'h3

`endif

//--- link_irq_pkg.sv
`include "link_irq_map.svh"

package link_irq_pkg;

  typedef enum logic [2:0] {
    LC_IDLE,
    LC_WAIT,
    LC_GAP,
    LC_LATE,
    LC_DONE,
    LC_PRED
  } lost_state_t;

  typedef struct packed {
    logic [`IEV_W-1:0] evt;
    logic [`IEV_W-1:0] src_prev;
    logic              cnt_lsb_prev;
    logic              sec_bit_prev;
    logic [1:0]        ctrl;
    lost_state_t       lost_st;
    logic [31:0]       rdata;
  } state_t;

endpackage : link_irq_pkg

//--- link_interrupt_event_low_bits.sv
// Overview of operation
// - Lost cycle when no start between syncs.
// - Predict lost cycle after first subaction gap.
// - Predict lost cycle on arbitration reset gap.
// - Sixty-four second event on seconds bit change.
// - Cycle sync event on cycle count toggle.
// - PHY event on status transfer request.
// - Access failed flag before next access.
// - Bus reset event on PHY bus reset.
// - Self-ID done; cleared when bus reset sets.
// - Sticky self-ID copy ignores bus reset.
// - Bits fourteen to ten read zero.
// - Lock response without ack complete flagged.
// - Posted write host error flagged.
// - Receive summary is OR of masked events.
// - Transmit summary is OR of masked events.
// - Response packet stored sets its bit.
// - Request packet stored sets its bit.
// - Receive response descriptor done sets bit.
// - Receive request descriptor done sets bit.
// - Response transmit command done sets bit.
// - Request transmit command done sets bit.
// - Set by edge or alias; cleared by clear alias, bit 16 also by bus reset.
// - Clear alias read returns events AND mask.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "link_irq_map.svh"

module link_interrupt_event_low_bits (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic [`ADDR_W-1:0]     addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output logic      [31:0]            rdata,
  input  wire logic                   cycle_count_lsb,
  input  wire logic                   cycle_seconds_bit6,
  input  wire logic                   cycle_start_pkt,
  input  wire logic                   subaction_gap,
  input  wire logic                   arb_reset_gap,
  input  wire logic                   other_pkt,
  input  wire logic                   phy_status_irq,
  input  wire logic                   reg_access_failed,
  input  wire logic                   phy_bus_reset,
  input  wire logic                   self_id_received,
  input  wire logic                   lock_response_no_ack,
  input  wire logic                   posted_write_host_err,
  input  wire logic [`ISO_CTX_N-1:0]  iso_rx_event,
  input  wire logic [`ISO_CTX_N-1:0]  iso_rx_mask,
  input  wire logic [`ISO_CTX_N-1:0]  iso_tx_event,
  input  wire logic [`ISO_CTX_N-1:0]  iso_tx_mask,
  input  wire logic                   response_packet_received,
  input  wire logic                   request_packet_received,
  input  wire logic                   async_rx_response_context_done,
  input  wire logic                   async_rx_request_context_done,
  input  wire logic                   async_tx_response_context_done,
  input  wire logic                   async_tx_request_context_done,
  input  wire logic [`IEV_W-1:0]      int_mask
);

  logic [1:0]                rst_pipe_q;
  logic                      rst_sync_n;
  link_irq_pkg::state_t      q;
  link_irq_pkg::state_t      d;
  logic                      iso_receive_summary;
  logic                      iso_transmit_summary;
  logic                      sync_pulse;
  logic                      sec64_pulse;
  logic                      lost_pulse;
  logic                      wr_set;
  logic                      wr_clr;
  logic                      wr_ctrl;
  logic [`IEV_W-1:0]         raw;
  logic [`IEV_W-1:0]         hw_set;
  logic [`IEV_W-1:0]         sw_set;
  logic [`IEV_W-1:0]         sw_clr;
  logic [`IEV_W-1:0]         set_all;
  logic [`IEV_W-1:0]         evt_view;
  logic                      bus_rst_rise;

  // Reset is released through two flops so its removal is clean.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_q[1];
  assign rdata      = q.rdata;

  always_comb begin
    d = q;
    iso_receive_summary  = |(iso_rx_event & iso_rx_mask);
    iso_transmit_summary = |(iso_tx_event & iso_tx_mask);
    sync_pulse  = cycle_count_lsb ^ q.cnt_lsb_prev;
    sec64_pulse = cycle_seconds_bit6 ^ q.sec_bit_prev;
    d.cnt_lsb_prev = cycle_count_lsb;
    d.sec_bit_prev = cycle_seconds_bit6;
    lost_pulse = 1'b0;

    // Tracks whether a cycle start arrived in the cycle opened by the last sync.
    case (q.lost_st)
      link_irq_pkg::LC_IDLE: begin
        if (sync_pulse) begin
          d.lost_st = link_irq_pkg::LC_WAIT;
        end
      end
      link_irq_pkg::LC_WAIT: begin
        if (sync_pulse) begin
          lost_pulse = 1'b1;
        end else if (cycle_start_pkt) begin
          d.lost_st = link_irq_pkg::LC_DONE;
        end else if (arb_reset_gap && q.ctrl[`CTRL_PRED_ARB]) begin
          lost_pulse = 1'b1;
          d.lost_st  = link_irq_pkg::LC_PRED;
        end else if (subaction_gap) begin
          d.lost_st = link_irq_pkg::LC_GAP;
        end
      end
      link_irq_pkg::LC_GAP: begin
        if (sync_pulse) begin
          lost_pulse = 1'b1;
          d.lost_st  = link_irq_pkg::LC_WAIT;
        end else if (cycle_start_pkt) begin
          d.lost_st = link_irq_pkg::LC_DONE;
        end else if ((other_pkt || subaction_gap || arb_reset_gap) && q.ctrl[`CTRL_PRED_GAP]) begin
          lost_pulse = 1'b1;
          d.lost_st  = link_irq_pkg::LC_PRED;
        end else if (arb_reset_gap && q.ctrl[`CTRL_PRED_ARB]) begin
          lost_pulse = 1'b1;
          d.lost_st  = link_irq_pkg::LC_PRED;
        end else if (other_pkt || subaction_gap) begin
          d.lost_st = link_irq_pkg::LC_LATE;
        end
      end
      link_irq_pkg::LC_LATE: begin
        if (sync_pulse) begin
          lost_pulse = 1'b1;
          d.lost_st  = link_irq_pkg::LC_WAIT;
        end else if (cycle_start_pkt) begin
          d.lost_st = link_irq_pkg::LC_DONE;
        end else if (arb_reset_gap && q.ctrl[`CTRL_PRED_ARB]) begin
          lost_pulse = 1'b1;
          d.lost_st  = link_irq_pkg::LC_PRED;
        end
      end
      default: begin
        // A predicted loss is not reported a second time at the next sync.
        if (sync_pulse) begin
          d.lost_st = link_irq_pkg::LC_WAIT;
        end
      end
    endcase

    raw = '0;
    raw[`IEV_LOST]    = lost_pulse;
    raw[`IEV_SEC64]   = sec64_pulse;
    raw[`IEV_SYNC]    = sync_pulse;
    raw[`IEV_PHY]     = phy_status_irq;
    raw[`IEV_REGFAIL] = reg_access_failed;
    raw[`IEV_BUSRST]  = phy_bus_reset;
    raw[`IEV_SELFID]  = self_id_received;
    raw[`IEV_SELFID2] = self_id_received;
    raw[`IEV_LOCKERR] = lock_response_no_ack;
    raw[`IEV_PWERR]   = posted_write_host_err;
    raw[`IEV_RSP_PKT] = response_packet_received;
    raw[`IEV_REQ_PKT] = request_packet_received;
    raw[`IEV_RX_RSP]  = async_rx_response_context_done;
    raw[`IEV_RX_REQ]  = async_rx_request_context_done;
    raw[`IEV_TX_RSP]  = async_tx_response_context_done;
    raw[`IEV_TX_REQ]  = async_tx_request_context_done;
    hw_set     = raw & ~q.src_prev & `IEV_LATCHED;
    // The derived bits are single-cycle pulses already, so back-to-back ones must each set.
    hw_set[`IEV_LOST]  = lost_pulse;
    hw_set[`IEV_SEC64] = sec64_pulse;
    hw_set[`IEV_SYNC]  = sync_pulse;
    d.src_prev = raw;

    wr_set  = wr_en && (addr == `IEV_SET_OFF);
    wr_clr  = wr_en && (addr == `IEV_CLR_OFF);
    wr_ctrl = wr_en && (addr == `IEV_CTRL_OFF);
    sw_set  = wr_set ? (wdata[`IEV_W-1:0] & `IEV_LATCHED) : '0;
    sw_clr  = wr_clr ? (wdata[`IEV_W-1:0] & `IEV_LATCHED) : '0;
    set_all = hw_set | sw_set;

    // A set arriving with a clear in the same cycle wins.
    d.evt = (q.evt & ~sw_clr) | set_all;
    bus_rst_rise = set_all[`IEV_BUSRST] && !q.evt[`IEV_BUSRST];
    if (bus_rst_rise && !set_all[`IEV_SELFID]) begin
      d.evt[`IEV_SELFID] = 1'b0;
    end

    if (wr_ctrl) begin
      d.ctrl = wdata[1:0];
    end

    evt_view = q.evt & `IEV_LATCHED;
    evt_view[`IEV_ISO_RX] = iso_receive_summary;
    evt_view[`IEV_ISO_TX] = iso_transmit_summary;

    d.rdata = 32'h0;
    if (rd_en) begin
      if (addr == `IEV_SET_OFF) begin
        d.rdata = {9'h0, evt_view};
      end else if (addr == `IEV_CLR_OFF) begin
        d.rdata = {9'h0, evt_view & int_mask};
      end else if (addr == `IEV_CTRL_OFF) begin
        d.rdata = {30'h0, q.ctrl};
      end else begin
        d.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q.evt          <= `IEV_RESET;
      q.src_prev     <= '0;
      q.cnt_lsb_prev <= 1'b0;
      q.sec_bit_prev <= 1'b0;
      q.ctrl         <= `CTRL_RESET;
      q.lost_st      <= link_irq_pkg::LC_IDLE;
      q.rdata        <= 32'h0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (!rst_sync_n);

  AST_LOST_MISSED: assert property (
    (q.lost_st == link_irq_pkg::LC_WAIT && sync_pulse) |=> q.evt[`IEV_LOST]
  ) else $error("Lost cycle not flagged at second sync.");

  AST_LOST_GAP: assert property (
    (q.lost_st == link_irq_pkg::LC_GAP && other_pkt && !cycle_start_pkt && !sync_pulse
     && q.ctrl[`CTRL_PRED_GAP]) |=> (q.evt[`IEV_LOST] && q.lost_st == link_irq_pkg::LC_PRED)
  ) else $error("Lost cycle not predicted after subaction gap.");

  AST_LOST_ARB: assert property (
    (q.lost_st == link_irq_pkg::LC_WAIT && arb_reset_gap && !cycle_start_pkt && !sync_pulse
     && q.ctrl[`CTRL_PRED_ARB]) |=> q.evt[`IEV_LOST]
  ) else $error("Lost cycle not predicted on arbitration reset gap.");

  AST_SEC64: assert property (
    (cycle_seconds_bit6 != $past(cycle_seconds_bit6)) ##1 1'b1 |-> q.evt[`IEV_SEC64]
  ) else $error("Seconds bit change did not set its event.");

  AST_SYNC: assert property (
    (cycle_count_lsb != q.cnt_lsb_prev) |=> (q.evt[`IEV_SYNC] && q.lost_st != link_irq_pkg::LC_IDLE)
  ) else $error("Cycle count toggle did not set sync event.");

  AST_PHY: assert property (
    (phy_status_irq && !q.src_prev[`IEV_PHY]) |=> q.evt[`IEV_PHY]
  ) else $error("PHY request did not set its event.");

  AST_REGFAIL: assert property (
    (reg_access_failed && !q.src_prev[`IEV_REGFAIL]) |=> q.evt[`IEV_REGFAIL]
  ) else $error("Access failure not flagged before next access.");

  AST_SELFID_CLR: assert property (
    (bus_rst_rise && !set_all[`IEV_SELFID]) |=> (!q.evt[`IEV_SELFID] && q.evt[`IEV_BUSRST])
  ) else $error("Self-ID done not cleared with bus reset.");

  AST_SELFID2_KEEP: assert property (
    (q.evt[`IEV_SELFID2] && !sw_clr[`IEV_SELFID2]) |=> q.evt[`IEV_SELFID2]
  ) else $error("Sticky self-ID copy lost without a clear.");

  AST_RSVD_ZERO: assert property (
    rd_en |=> (rdata[14:10] == 5'h00 && rdata[31:23] == 9'h000)
  ) else $error("Reserved bits read nonzero.");

  AST_ISO_RX: assert property (
    (rd_en && addr == `IEV_SET_OFF) |=> rdata[`IEV_ISO_RX] == $past(|(iso_rx_event & iso_rx_mask))
  ) else $error("Receive summary does not match masked events.");

  AST_TX_REQ_SET: assert property (
    $rose(async_tx_request_context_done) |=> q.evt[`IEV_TX_REQ]
  ) else $error("Request transmit done did not set its event.");

  AST_CLR_ONLY: assert property (
    (wr_en && addr == `IEV_CLR_OFF && wdata[`IEV_RX_REQ] && !hw_set[`IEV_RX_REQ]) |=> !q.evt[`IEV_RX_REQ]
  ) else $error("Clear alias write did not clear event.");

  AST_CLR_READ: assert property (
    (rd_en && addr == `IEV_CLR_OFF) |=> rdata[`IEV_W-1:0] == ($past(evt_view) & $past(int_mask))
  ) else $error("Clear alias read is not events AND mask.");

  AST_ZERO_WRITE: assert property (
    (wr_en && wdata[`IEV_W-1:0] == '0 && hw_set == '0) |=> q.evt == $past(q.evt)
  ) else $error("Zero write changed event bits.");

  AST_BUSRST_SET: assert property (
    (phy_bus_reset && !q.src_prev[`IEV_BUSRST]) |=> q.evt[`IEV_BUSRST]
  ) else $error("Bus reset did not set its event.");

  AST_SELFID_SET: assert property (
    (self_id_received && !q.src_prev[`IEV_SELFID]) |=> (q.evt[`IEV_SELFID] && q.evt[`IEV_SELFID2])
  ) else $error("Self-ID done did not set both bits.");

  AST_LOCKERR_SET: assert property (
    (lock_response_no_ack && !q.src_prev[`IEV_LOCKERR]) |=> q.evt[`IEV_LOCKERR]
  ) else $error("Lock response error did not set its event.");

  AST_PWERR_SET: assert property (
    (posted_write_host_err && !q.src_prev[`IEV_PWERR]) |=> q.evt[`IEV_PWERR]
  ) else $error("Posted write error did not set its event.");

  AST_ISO_TX: assert property (
    (rd_en && addr == `IEV_SET_OFF) |=> rdata[`IEV_ISO_TX] == $past(|(iso_tx_event & iso_tx_mask))
  ) else $error("Transmit summary does not match masked events.");

  AST_RSP_PKT_SET: assert property (
    (response_packet_received && !q.src_prev[`IEV_RSP_PKT]) |=> q.evt[`IEV_RSP_PKT]
  ) else $error("Response packet stored did not set its event.");

  AST_REQ_PKT_SET: assert property (
    (request_packet_received && !q.src_prev[`IEV_REQ_PKT]) |=> q.evt[`IEV_REQ_PKT]
  ) else $error("Request packet stored did not set its event.");

  AST_RX_RSP_SET: assert property (
    (async_rx_response_context_done && !q.src_prev[`IEV_RX_RSP]) |=> q.evt[`IEV_RX_RSP]
  ) else $error("Receive response descriptor done did not set its event.");

  AST_RX_REQ_SET: assert property (
    (async_rx_request_context_done && !q.src_prev[`IEV_RX_REQ]) |=> q.evt[`IEV_RX_REQ]
  ) else $error("Receive request descriptor done did not set its event.");

  AST_TX_RSP_SET: assert property (
    (async_tx_response_context_done && !q.src_prev[`IEV_TX_RSP]) |=> q.evt[`IEV_TX_RSP]
  ) else $error("Response transmit done did not set its event.");

  AST_SET_ALIAS: assert property (
    (wr_en && addr == `IEV_SET_OFF && wdata[`IEV_PHY]) |=> q.evt[`IEV_PHY]
  ) else $error("Set alias write did not set event.");

  AST_PRED_ONCE: assert property (
    (q.lost_st == link_irq_pkg::LC_PRED && sync_pulse && !q.evt[`IEV_LOST] && !wr_set)
    |=> (!q.evt[`IEV_LOST] && q.lost_st == link_irq_pkg::LC_WAIT)
  ) else $error("Predicted loss flagged again at the next sync.");

endmodule : link_interrupt_event_low_bits

//--- link_side_model.sv
`timescale 1ns/1ps

module link_side_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [17:0] req,
  output logic      [15:0] pulse_q,
  output logic             cyc_lsb_q,
  output logic             sec_bit_q
);

  // Each of request bits 15 to 0 becomes a one-cycle event pulse.
  // The two counter bits are levels that toggle on request.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q   <= 16'h0000;
      cyc_lsb_q <= 1'b0;
      sec_bit_q <= 1'b0;
    end else begin
      pulse_q   <= req[15:0];
      cyc_lsb_q <= cyc_lsb_q ^ req[16];
      sec_bit_q <= sec_bit_q ^ req[17];
    end
  end

endmodule : link_side_model

//--- tb_link_interrupt_event_low_bits.sv
`timescale 1ns/1ps

module tb_link_interrupt_event_low_bits;
  logic        clock, rst_n, wr_en, rd_en;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask;
  logic [22:0] int_mask;
  logic [17:0] req;
  logic [15:0] pulses;
  logic        cycle_count_lsb, cycle_seconds_bit6, cycle_start_pkt, subaction_gap, arb_reset_gap;
  logic        other_pkt, phy_status_irq, reg_access_failed, phy_bus_reset, self_id_received;
  logic        lock_response_no_ack, posted_write_host_err, response_packet_received;
  logic        request_packet_received, async_rx_response_context_done, async_rx_request_context_done;
  logic        async_tx_response_context_done, async_tx_request_context_done;
  int          n_errors, samples_checked;
  int          evb [18] = '{0, 0, 0, 0, 19, 18, 17, 16, 9, 8, 5, 4, 3, 2, 1, 0, 20, 21};

  assign {async_tx_request_context_done, async_tx_response_context_done, async_rx_request_context_done,
          async_rx_response_context_done, request_packet_received, response_packet_received,
          posted_write_host_err, lock_response_no_ack, self_id_received, phy_bus_reset,
          reg_access_failed, phy_status_irq, other_pkt, arb_reset_gap, subaction_gap,
          cycle_start_pkt} = pulses;

  link_side_model partner (.clock, .rst_n, .req, .pulse_q(pulses), .cyc_lsb_q(cycle_count_lsb),
                           .sec_bit_q(cycle_seconds_bit6));

  link_interrupt_event_low_bits uut (.clock, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .cycle_count_lsb, .cycle_seconds_bit6, .cycle_start_pkt, .subaction_gap, .arb_reset_gap,
    .other_pkt, .phy_status_irq, .reg_access_failed, .phy_bus_reset, .self_id_received,
    .lock_response_no_ack, .posted_write_host_err, .iso_rx_event, .iso_rx_mask, .iso_tx_event,
    .iso_tx_mask, .response_packet_received, .request_packet_received,
    .async_rx_response_context_done, .async_rx_request_context_done,
    .async_tx_response_context_done, .async_tx_request_context_done, .int_mask);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic finish_test;
    $display("Checked %0d values, %0d errors", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    check_word(rdata, exp);
  endtask : rd

  task automatic fire(input int i);
    @(posedge clock);
    req <= 18'h00001 << i;
    @(posedge clock);
    req <= 18'h00000;
    repeat (4) @(posedge clock);
  endtask : fire

  initial begin
    {rst_n, wr_en, rd_en, addr, wdata, req, int_mask} = '0;
    {iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask} = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(8'h80, 32'h0);
    rd(8'hFC, 32'h3);
    for (int r = 0; r < 2; r++) begin
      for (int i = 4; i < 18; i++) begin
        fire(i);
        rd(8'h80, (32'h1 << evb[i]) | (i == 7 ? 32'h8000 : 32'h0) | (i == 16 && r == 1 ? 32'h400000 : 32'h0));
        wr(8'h84, 32'hFFFFFFFF);
        rd(8'h80, 32'h0);
      end
    end
    fire(7);
    fire(6);
    rd(8'h80, 32'h28000);
    wr(8'h84, 32'hFFFFFFFF);
    fire(0);
    fire(16);
    fire(0);
    fire(16);
    rd(8'h80, 32'h100000);
    wr(8'h84, 32'hFFFFFFFF);
    fire(2);
    rd(8'h80, 32'h400000);
    wr(8'h84, 32'hFFFFFFFF);
    fire(16);
    fire(1);
    fire(3);
    rd(8'h80, 32'h500000);
    wr(8'h84, 32'hFFFFFFFF);
    fire(16);
    wr(8'hFC, 32'h0);
    rd(8'hFC, 32'h0);
    wr(8'h84, 32'hFFFFFFFF);
    fire(1);
    fire(3);
    fire(2);
    rd(8'h80, 32'h0);
    fire(16);
    rd(8'h80, 32'h500000);
    wr(8'hFC, 32'h3);
    wr(8'h84, 32'hFFFFFFFF);
    wr(8'h80, 32'hFFFEFFFF);
    rd(8'h80, 32'h7E833F);
    wr(8'h80, 32'h0);
    wr(8'h84, 32'h0);
    rd(8'h80, 32'h7E833F);
    @(posedge clock);
    int_mask <= 23'h555555;
    rd(8'h84, 32'h7E833F & 32'h555555);
    wr(8'h84, 32'hF);
    rd(8'h80, 32'h7E8330);
    wr(8'h84, 32'hFFFFFFFF);
    @(posedge clock);
    iso_rx_event <= 32'h80000000;
    iso_rx_mask  <= 32'h80000000;
    iso_tx_event <= 32'h00000001;
    rd(8'h80, 32'h80);
    rd(8'h84, 32'h0);
    @(posedge clock);
    iso_tx_mask <= 32'h00000001;
    rd(8'h80, 32'hC0);
    rd(8'h84, 32'h40);
    @(posedge clock);
    iso_rx_mask <= 32'h0;
    rd(8'h80, 32'h40);
    rd(8'h88, 32'h0);
    finish_test();
  end

  // The tests need well under 2000 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    finish_test();
  end

endmodule : tb_link_interrupt_event_low_bits
